// file: logic/hsmc_ctrl.sv
// top: state and playback-mode controller for a haptic driver
`timescale 1ns/100ps
module hsmc_ctrl
	import hsmc_pkg::*;
#(
	parameter int IDLE_WAKE = IDLE_WAKE_CYC,
	parameter int STBY_WAKE = STBY_WAKE_CYC,
	parameter int PWM_MEAS_W = 8
) (
	input wire logic CLK_I, // 20 MHz clock
	input wire logic RESETN_I, // async reset, low
	input wire logic [2:0] MODE_I, // playback source field
	input wire logic STANDBY_EN_I, // low-latency return enable
	input wire logic [7:0] STREAMED_DRIVE_LEVEL_I, // register stream level
	input wire logic SEQUENCE_TRIGGER_I, // serial write of 1, pulse
	input wire logic [2:0] TRIG_PIN_I, // trigger pins, pin 0 also pwm
	input wire logic [2:0] TRIG_EDGE_FALL_I, // per pin: 1 falling, 0 rising
	input wire logic SEQ_END_I, // memory sequence ended, pulse
	input wire logic STREAM_STOP_I, // stop streaming playback, pulse
	input wire hsmc_feat_s FEAT_I, // loop and feature enables
	input wire logic [7:0] WAVE_SHAPE_I, // custom wave sample
	input wire logic WAVE_CUSTOM_I, // use custom shape in open loop, else sine
	input wire logic [7:0] SUPPLY_LEVEL_I, // measured supply, 255 full
	input wire hsmc_fault_s FAULT_I, // fault detect levels
	input wire logic TEMP_WARN_I, // over-temperature warning level
	input wire logic FAULT_CLEAR_I, // host clears fault flags, pulse
	input wire logic DONE_CLEAR_I, // host clears done flag, pulse
	output logic [4:0] STATE_O, // controller state
	output logic BOOT_LOAD_O, // defaults being loaded
	output logic REG_PORT_READY_O, // serial port serviceable
	output logic [2:0] ACTIVE_MODE_O, // latched playback source
	output logic [7:0] DRIVE_LEVEL_O, // scaled drive level
	output logic [7:0] SUPPLY_READ_O, // supply readback
	output logic [7:0] WAVE_SAMPLE_O, // wave shape in use
	output logic BACK_EMF_SENSE_EN_O, // back-emf monitoring on
	output hsmc_feat_s FEAT_EN_O, // effective feature enables
	output logic DRIVE_OUT_POS_O, // bridge positive
	output logic DRIVE_OUT_POS_OE_O, // bridge positive enable
	output logic DRIVE_OUT_NEG_O, // bridge negative
	output logic DRIVE_OUT_NEG_OE_O, // bridge negative enable
	output logic [2:0] FAULT_FLAGS_O, // sticky fault flags
	output logic TEMP_WARN_O, // temperature warning flag
	output logic SEQUENCE_COMPLETE_FLAG_O, // sticky done flag
	output logic ATTENTION_PIN_N_O // attention pin, low active
);
	hsmc_state_e state, next_state;
	logic [4:0] boot_cnt;
	logic [15:0] wake_cnt;
	logic [2:0] pin_q;
	logic [2:0] edge_hit;
	logic [2:0] mode;
	logic [2:0] fault_flags;
	logic fault_now, req;
	logic [PWM_MEAS_W-1:0] pwm_hi, pwm_duty;
	logic [7:0] level_raw;
	logic pwm_bit;

	function automatic logic [7:0] scale(input logic [7:0] a, input logic [7:0] b);
		logic [15:0] p;
		p = 16'(a) * 16'(b);
		return p[15:8];
	endfunction

	// ------------------------------------------------------------
	// boot and fault handling
	// ------------------------------------------------------------
	assign fault_now = |FAULT_I;

	// boot count advances only while booting, so it holds its value afterwards
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			boot_cnt <= 5'h00;
		end else if (state == ST_BOOT) begin
			boot_cnt <= boot_cnt + 5'h01;
		end
	end

	// sticky: a new fault wins over a clear in the same cycle
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			fault_flags <= 3'h0;
			TEMP_WARN_O <= 1'b0;
		end else begin
			fault_flags <= (FAULT_CLEAR_I ? 3'h0 : fault_flags) | FAULT_I;
			TEMP_WARN_O <= (FAULT_CLEAR_I ? 1'b0 : TEMP_WARN_O) | TEMP_WARN_I;
		end
	end

	// ------------------------------------------------------------
	// trigger decode
	// ------------------------------------------------------------
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			pin_q <= 3'h0;
		end else begin
			pin_q <= TRIG_PIN_I;
		end
	end

	// edges seen during boot are dropped, so a pin idling high gives no false start
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			edge_hit[i] = TRIG_EDGE_FALL_I[i] ? (pin_q[i] && !TRIG_PIN_I[i])
				: (!pin_q[i] && TRIG_PIN_I[i]);
		end
	end

	// requests only evaluated against the live field while not driving
	always_comb begin
		req = 1'b0;
		unique case (MODE_I)
			MODE_REG_STREAM: req = 1'b1;
			MODE_PWM_STREAM: req = 1'b1;
			MODE_REG_TRIG: req = SEQUENCE_TRIGGER_I;
			MODE_EDGE_TRIG: req = SEQUENCE_TRIGGER_I || (|edge_hit);
			default: req = 1'b0;
		endcase
		// a live fault blocks too, so a request cannot race the flag set
		if (|fault_flags || fault_now) begin
			req = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// state machine
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			ST_BOOT: if (boot_cnt == 5'(BOOT_CYC - 1)) next_state = ST_IDLE;
			ST_IDLE: if (req) next_state = ST_WAKE;
			ST_STBY: begin
				if (req) next_state = ST_WAKE;
				else if (!STANDBY_EN_I) next_state = ST_IDLE;
			end
			ST_WAKE: if (wake_cnt == 16'h0000) next_state = ST_DRIVE;
			ST_DRIVE: begin
				if (SEQ_END_I || STREAM_STOP_I || mode == MODE_INACTIVE) begin
					next_state = STANDBY_EN_I ? ST_STBY : ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		if (fault_now && state != ST_BOOT) begin
			next_state = ST_IDLE;
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state <= ST_BOOT;
		end else begin
			state <= next_state;
		end
	end

	// wake delay chosen by the state the request came from
	// a request in wake or drive is dropped, not queued
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			wake_cnt <= 16'h0000;
		end else if (state == ST_IDLE && req) begin
			wake_cnt <= 16'(IDLE_WAKE);
		end else if (state == ST_STBY && req) begin
			wake_cnt <= 16'(STBY_WAKE);
		end else if (state == ST_WAKE && wake_cnt != 16'h0000) begin
			wake_cnt <= wake_cnt - 16'h0001;
		end
	end

	// mode latched at acceptance of a request
	// a field change in drive waits for the next request
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			mode <= MODE_RST;
		end else if ((state == ST_IDLE || state == ST_STBY) && req) begin
			mode <= MODE_I;
		end
	end

	// ------------------------------------------------------------
	// pwm input demodulation on trigger pin 0
	// ------------------------------------------------------------
	// duty is the high time of the last input period, saturating at full scale;
	// the period itself is not measured, so the input rate sets the scale
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			pwm_hi <= '0;
			pwm_duty <= '0;
		end else if (!pin_q[0] && TRIG_PIN_I[0]) begin
			pwm_duty <= pwm_hi;
			pwm_hi <= '0;
		end else begin
			if (TRIG_PIN_I[0] && pwm_hi != '1) begin
				pwm_hi <= pwm_hi + 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// drive level and outputs
	// ------------------------------------------------------------
	always_comb begin
		level_raw = 8'h00;
		unique case (mode)
			MODE_REG_STREAM: level_raw = STREAMED_DRIVE_LEVEL_I;
			MODE_PWM_STREAM: level_raw = 8'(pwm_duty);
			MODE_REG_TRIG, MODE_EDGE_TRIG: level_raw = 8'hFF;
			default: level_raw = 8'h00;
		endcase
	end

	// registers held by ports, except the drive level, are untouched by state changes
	// level is zero outside drive so a stale stream value never leaks
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			DRIVE_LEVEL_O <= LEVEL_RST;
			SUPPLY_READ_O <= 8'h00;
			WAVE_SAMPLE_O <= 8'h00;
			FEAT_EN_O <= FEAT_RST;
			BACK_EMF_SENSE_EN_O <= 1'b0;
		end else begin
			DRIVE_LEVEL_O <= (state == ST_DRIVE) ? scale(level_raw, SUPPLY_LEVEL_I) : 8'h00;
			SUPPLY_READ_O <= SUPPLY_LEVEL_I;
			WAVE_SAMPLE_O <= (FEAT_I.closed_loop || !WAVE_CUSTOM_I) ? 8'h80 : WAVE_SHAPE_I;
			BACK_EMF_SENSE_EN_O <= FEAT_I.closed_loop;
			FEAT_EN_O <= FEAT_I.closed_loop ? FEAT_I : FEAT_RST;
		end
	end

	// carrier held cleared outside drive so each burst starts a full period
	hsmc_pwm_carrier #(
		.DIV(PWM_DIV)
	) u_carrier (
		.clk_i(CLK_I),
		.resetn_i(RESETN_I),
		.run_i(state == ST_DRIVE),
		.duty_i(DRIVE_LEVEL_O),
		.pwm_o(pwm_bit)
	);

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			DRIVE_OUT_POS_O <= 1'b0;
			DRIVE_OUT_NEG_O <= 1'b0;
			DRIVE_OUT_POS_OE_O <= 1'b0;
			DRIVE_OUT_NEG_OE_O <= 1'b0;
		end else begin
			DRIVE_OUT_POS_O <= pwm_bit;
			DRIVE_OUT_NEG_O <= !pwm_bit;
			// short or over-temperature releases the bridge at once
			DRIVE_OUT_POS_OE_O <= state == ST_DRIVE && !FAULT_I.short_out && !FAULT_I.over_temp;
			DRIVE_OUT_NEG_OE_O <= state == ST_DRIVE && !FAULT_I.short_out && !FAULT_I.over_temp;
		end
	end

	// ------------------------------------------------------------
	// sequence done
	// ------------------------------------------------------------
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			SEQUENCE_COMPLETE_FLAG_O <= 1'b0;
		end else if (state == ST_DRIVE && SEQ_END_I) begin
			SEQUENCE_COMPLETE_FLAG_O <= 1'b1;
		end else if (DONE_CLEAR_I) begin
			SEQUENCE_COMPLETE_FLAG_O <= 1'b0;
		end
	end

	assign ATTENTION_PIN_N_O = !SEQUENCE_COMPLETE_FLAG_O;
	assign STATE_O = state;
	assign BOOT_LOAD_O = state == ST_BOOT;
	assign REG_PORT_READY_O = state != ST_BOOT;
	assign ACTIVE_MODE_O = mode;
	assign FAULT_FLAGS_O = fault_flags;
endmodule

// file: logic/hsmc_pkg.sv
// package: constants and types for the haptic state and mode controller
package hsmc_pkg;
	// playback source codes
	localparam logic [2:0] MODE_INACTIVE = 3'h0;
	localparam logic [2:0] MODE_REG_STREAM = 3'h1;
	localparam logic [2:0] MODE_PWM_STREAM = 3'h2;
	localparam logic [2:0] MODE_REG_TRIG = 3'h3;
	localparam logic [2:0] MODE_EDGE_TRIG = 3'h4;
	// timing
	localparam int CLK_HZ = 20000000;
	localparam int IDLE_WAKE_NS = 750000;
	localparam int STBY_WAKE_NS = 150000;
	localparam int IDLE_WAKE_CYC = (IDLE_WAKE_NS / 50) - 1;
	localparam int STBY_WAKE_CYC = (STBY_WAKE_NS / 50) - 1;
	localparam int PWM_CARRIER_HZ = 187500;
	localparam int PWM_DIV = CLK_HZ / PWM_CARRIER_HZ;
	localparam int BOOT_CYC = 16;
	// reset values
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [7:0] LEVEL_RST = 8'h00;
	localparam logic [4:0] FEAT_RST = 5'h00;

	typedef enum logic [4:0] {
		ST_BOOT = 5'h01,
		ST_IDLE = 5'h02,
		ST_STBY = 5'h04,
		ST_WAKE = 5'h08,
		ST_DRIVE = 5'h10
	} hsmc_state_e;

	// closed-loop feature enables
	typedef struct packed {
		logic closed_loop;
		logic freq_track_en;
		logic accel_en;
		logic rapid_stop_en;
		logic amp_ctrl_en;
	} hsmc_feat_s;

	// fault sources
	typedef struct packed {
		logic short_out;
		logic over_temp;
		logic actuator;
	} hsmc_fault_s;
endpackage

// file: logic/hsmc_pwm_carrier.sv
// fixed-carrier pwm generator for the output bridge
`timescale 1ns/100ps
module hsmc_pwm_carrier
	import hsmc_pkg::*;
#(
	parameter int DIV = PWM_DIV
) (
	input wire logic clk_i, // clock
	input wire logic resetn_i, // async reset, low
	input wire logic run_i, // carrier enabled
	input wire logic [7:0] duty_i, // duty, 0..255 of a period
	output logic pwm_o // carrier output
);
	logic [7:0] cnt;
	logic [15:0] thr;

	assign thr = 16'(duty_i) * 16'(DIV);

	// ------------------------------------------------------------
	// carrier counter
	// ------------------------------------------------------------
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt <= 8'h00;
		end else if (!run_i || cnt == 8'(DIV - 1)) begin
			cnt <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pwm_o <= 1'b0;
		end else begin
			pwm_o <= run_i && ({cnt, 8'h00} < thr);
		end
	end
endmodule

// file: sim/hsmc_host_model.sv
// host and trigger pin model at the controller's far side
`timescale 1ns/100ps
module hsmc_host_model (
	input wire logic clk_i, // clock
	output logic [2:0] pins_o, // trigger pins
	output logic trig_o // serial trigger write
);
	initial begin
		pins_o = 3'h0;
		trig_o = 1'b0;
	end
	// a register write of one lasts a single clock
	task automatic write_trigger();
		@(posedge clk_i);
		#1 trig_o = 1'b1;
		@(posedge clk_i);
		#1 trig_o = 1'b0;
	endtask
	task automatic flip_pin(input int i);
		@(posedge clk_i);
		#1 pins_o[i] = !pins_o[i];
	endtask
endmodule

// file: sim/hsmc_ctrl_checker.sv
// assertions for the haptic state and mode controller
`timescale 1ns/100ps
module hsmc_ctrl_checker
	import hsmc_pkg::*;
#(
	parameter int IDLE_WAKE = IDLE_WAKE_CYC,
	parameter int STBY_WAKE = STBY_WAKE_CYC
) (
	input wire logic CLK_I, // clock
	input wire logic RESETN_I, // reset
	input wire logic STANDBY_EN_I, // standby
	input wire logic SEQ_END_I, // end
	input wire hsmc_feat_s FEAT_I, // features
	input wire hsmc_fault_s FAULT_I, // faults
	input wire logic [4:0] STATE_O, // state
	input wire logic [2:0] ACTIVE_MODE_O, // mode
	input wire logic BACK_EMF_SENSE_EN_O, // back_emf_sense
	input wire hsmc_feat_s FEAT_EN_O, // enables
	input wire logic DRIVE_OUT_POS_OE_O, // pos oe
	input wire logic DRIVE_OUT_NEG_OE_O, // neg oe
	input wire logic [2:0] FAULT_FLAGS_O, // flags
	input wire logic SEQUENCE_COMPLETE_FLAG_O, // done
	input wire logic ATTENTION_PIN_N_O // attention
);
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!RESETN_I);
	logic [15:0] wcnt;
	logic from_idle;
	// wake length and origin, so latency is judged per start state
	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			wcnt <= 16'h0000;
			from_idle <= 1'b0;
		end else if (STATE_O != ST_WAKE) begin
			wcnt <= 16'h0000;
			from_idle <= (STATE_O == ST_IDLE);
		end else begin
			wcnt <= wcnt + 16'h0001;
		end
	end
	sequence enter_drive;
		STATE_O == ST_WAKE ##1 STATE_O == ST_DRIVE;
	endsequence
	idle_wake_a: assert property (enter_drive ##0 from_idle |-> wcnt == IDLE_WAKE + 1)
		else $error("idle wake time wrong");
	stby_wake_a: assert property (enter_drive ##0 !from_idle |-> wcnt == STBY_WAKE + 1)
		else $error("standby wake time wrong");
	oe_on_a: assert property (enter_drive ##0 FAULT_I == 3'h0 |=>
		DRIVE_OUT_POS_OE_O && DRIVE_OUT_NEG_OE_O) else $error("bridge not enabled");
	on_fault_a: assert property (FAULT_I != 3'h0 && STATE_O != ST_BOOT |=>
		STATE_O == ST_IDLE) else $error("fault did not force idle");
	short_hiz_a: assert property (FAULT_I.short_out |=>
		!DRIVE_OUT_POS_OE_O && !DRIVE_OUT_NEG_OE_O) else $error("bridge driven in short");
	temp_hiz_a: assert property (FAULT_I.over_temp |=>
		!DRIVE_OUT_POS_OE_O && !DRIVE_OUT_NEG_OE_O) else $error("bridge driven when hot");
	play_end_a: assert property (STATE_O == ST_DRIVE && SEQ_END_I && FAULT_I == 3'h0 |=>
		STATE_O == ($past(STANDBY_EN_I) ? ST_STBY : ST_IDLE)) else $error("wrong end state");
	done_flag_a: assert property (STATE_O == ST_DRIVE && SEQ_END_I &&
		ACTIVE_MODE_O >= MODE_REG_TRIG |=> SEQUENCE_COMPLETE_FLAG_O && !ATTENTION_PIN_N_O)
		else $error("done not reported");
	open_loop_a: assert property (!FEAT_I.closed_loop |=>
		!BACK_EMF_SENSE_EN_O && FEAT_EN_O == 5'h00) else $error("open loop features on");
	fault_block_a: assert property (FAULT_FLAGS_O != 3'h0 && STATE_O == ST_IDLE |=>
		STATE_O != ST_WAKE) else $error("woke with faults pending");
endmodule

bind hsmc_ctrl hsmc_ctrl_checker #(.IDLE_WAKE(IDLE_WAKE), .STBY_WAKE(STBY_WAKE)) chk_i (
	.CLK_I(CLK_I), .RESETN_I(RESETN_I), .STANDBY_EN_I(STANDBY_EN_I), .SEQ_END_I(SEQ_END_I),
	.FEAT_I(FEAT_I), .FAULT_I(FAULT_I), .STATE_O(STATE_O), .ACTIVE_MODE_O(ACTIVE_MODE_O),
	.BACK_EMF_SENSE_EN_O(BACK_EMF_SENSE_EN_O), .FEAT_EN_O(FEAT_EN_O), .DRIVE_OUT_POS_OE_O(DRIVE_OUT_POS_OE_O),
	.DRIVE_OUT_NEG_OE_O(DRIVE_OUT_NEG_OE_O), .FAULT_FLAGS_O(FAULT_FLAGS_O),
	.SEQUENCE_COMPLETE_FLAG_O(SEQUENCE_COMPLETE_FLAG_O), .ATTENTION_PIN_N_O(ATTENTION_PIN_N_O));

// file: sim/tb_hsmc_ctrl.sv
// self-checking testbench for the haptic state and mode controller
`timescale 1ns/100ps
module tb_hsmc_ctrl;
	import hsmc_pkg::*;
	localparam int IW = 20;
	localparam int SW = 5;
	logic clk = 1'b0, rst_n = 1'b0, sby = 1'b0, s_end = 1'b0, s_stop = 1'b0;
	logic f_clr = 1'b0, d_clr = 1'b0, t_warn = 1'b0, custom = 1'b0;
	logic [2:0] mode = 3'h0;
	logic [7:0] lvl = 8'h40, sup = 8'hC0, shape = 8'h35;
	hsmc_feat_s feat = 5'h00;
	hsmc_fault_s flt = 3'h0;
	hsmc_feat_s fen;
	logic [4:0] st;
	logic [2:0] pins, amode, fflags;
	logic [7:0] dlvl, supr, wave;
	logic trig, back_emf_sense, p_oe, n_oe, twarn, done, att_n;
	int fails = 0, check_count = 0, n;

	hsmc_host_model host (.clk_i(clk), .pins_o(pins), .trig_o(trig));
	hsmc_ctrl #(.IDLE_WAKE(IW), .STBY_WAKE(SW)) uut (
		.CLK_I(clk), .RESETN_I(rst_n), .MODE_I(mode), .STANDBY_EN_I(sby),
		.STREAMED_DRIVE_LEVEL_I(lvl), .SEQUENCE_TRIGGER_I(trig), .TRIG_PIN_I(pins),
		.TRIG_EDGE_FALL_I(3'h2), .SEQ_END_I(s_end), .STREAM_STOP_I(s_stop), .FEAT_I(feat),
		.WAVE_SHAPE_I(shape), .WAVE_CUSTOM_I(custom), .SUPPLY_LEVEL_I(sup), .FAULT_I(flt),
		.TEMP_WARN_I(t_warn), .FAULT_CLEAR_I(f_clr), .DONE_CLEAR_I(d_clr), .STATE_O(st),
		.BOOT_LOAD_O(), .REG_PORT_READY_O(), .ACTIVE_MODE_O(amode), .DRIVE_LEVEL_O(dlvl),
		.SUPPLY_READ_O(supr), .WAVE_SAMPLE_O(wave), .BACK_EMF_SENSE_EN_O(back_emf_sense), .FEAT_EN_O(fen),
		.DRIVE_OUT_POS_O(), .DRIVE_OUT_POS_OE_O(p_oe), .DRIVE_OUT_NEG_O(),
		.DRIVE_OUT_NEG_OE_O(n_oe), .FAULT_FLAGS_O(fflags), .TEMP_WARN_O(twarn),
		.SEQUENCE_COMPLETE_FLAG_O(done), .ATTENTION_PIN_N_O(att_n));

	initial begin
		forever #25 clk = !clk;
	end

	task automatic tick(input int k = 1);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// bounded wait for a state; n holds the edges it took
	task automatic wait_st(input logic [4:0] s, input int lim);
		n = 0;
		while (st !== s && n < lim) begin
			tick();
			n++;
		end
		chk("state", s, st);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		final_report();
	end

	initial begin
		repeat (4) @(posedge clk);
		#1 rst_n = 1'b1;
		tick(15);
		chk("boot", ST_BOOT, st);
		wait_st(ST_IDLE, 3);
		custom = 1'b1;
		tick(2);
		chk("open", 6'h00, {back_emf_sense, fen});
		chk("custom", shape, wave);
		feat = 5'h1A;
		custom = 1'b0;
		tick(2);
		chk("closed", 6'h3A, {back_emf_sense, fen});
		chk("sine", 8'h80, wave);
		chk("idle kept", ST_IDLE, st);
		$display("boot and config test done");
		// rising edge on a falling-edge pin, then a falling one
		for (int m = 3; m < 5; m++) begin
			mode = m[2:0];
			host.flip_pin(1);
			tick(3);
			if (m == 3) begin
				// rising edge on rising-edge pin 2: only mode 4 may take it
				host.flip_pin(2);
				tick(2);
				chk("pin ignored", ST_IDLE, st);
				host.write_trigger();
			end
			wait_st(ST_DRIVE, IW + 4);
			if (m == 3)
				chk("idle wake", IW + 1, n);
			mode = MODE_INACTIVE;
			tick(2);
			chk("mode kept", m, amode);
			chk("oe", 2'b11, {p_oe, n_oe});
			s_end = 1'b1;
			tick();
			s_end = 1'b0;
			chk("end idle", ST_IDLE, st);
			chk("done", 2'b10, {done, att_n});
			d_clr = 1'b1;
			tick();
			d_clr = 1'b0;
			tick();
			chk("cleared", 2'b01, {done, att_n});
			$display("memory mode test done");
		end
		sby = 1'b1;
		mode = MODE_REG_STREAM;
		wait_st(ST_DRIVE, IW + 5);
		tick();
		chk("level", (16'(lvl) * 16'(sup)) >> 8, dlvl);
		chk("supply", sup, supr);
		mode = MODE_INACTIVE;
		s_stop = 1'b1;
		tick();
		s_stop = 1'b0;
		chk("standby", ST_STBY, st);
		tick(5);
		chk("inactive", ST_STBY, st);
		mode = MODE_REG_TRIG;
		host.write_trigger();
		wait_st(ST_DRIVE, SW + 4);
		chk("stby wake", SW + 1, n);
		$display("stream and standby test done");
		flt = 3'h4;
		tick();
		chk("fault idle", ST_IDLE, st);
		chk("hi z", 2'b00, {p_oe, n_oe});
		flt = 3'h0;
		host.write_trigger();
		tick(3);
		chk("blocked", ST_IDLE, st);
		chk("flags", 3'h4, fflags);
		f_clr = 1'b1;
		tick();
		f_clr = 1'b0;
		host.write_trigger();
		chk("accepted", ST_WAKE, st);
		wait_st(ST_DRIVE, IW + 4);
		s_end = 1'b1;
		tick();
		s_end = 1'b0;
		sby = 1'b0;
		mode = MODE_PWM_STREAM;
		wait_st(ST_DRIVE, SW + 5);
		// pin 0 high for 64 cycles: duty 0x40, scaled by supply 0xC0 gives 0x30
		host.flip_pin(0);
		tick(64);
		host.flip_pin(0);
		tick(20);
		host.flip_pin(0);
		tick(2);
		chk("pwm level", 16'h0030, dlvl);
		t_warn = 1'b1;
		flt = 3'h2;
		tick();
		chk("overtemp", ST_IDLE, st);
		chk("overtemp oe", 2'b00, {p_oe, n_oe});
		tick();
		chk("warn", 1'b1, twarn);
		mode = MODE_INACTIVE;
		flt = 3'h0;
		t_warn = 1'b0;
		$display("fault test done");
		tick(2);
		final_report();
	end
endmodule
